// File: src/spcb_bridge.sv
// Serial command bridge driving a power-line carrier interface module
// Functional notes
// - The host link runs 7 data bits, even parity, 1 stop when format select is high, else 8N1.
// - Serial level select high inverts both serial pins, low leaves them true.
// - Rate code {rate_select_0,1,2} picks 9600,4800,2400,1200,600,300 bit/s for 000 to 101.
// - Straps are sampled on the first clock after each reset and the board holds them fixed afterwards.
// - The bridge is held in reset while the active-low reset input is low.
// - The bridge makes all power-line transmit timing and encoding and drives line_tx.
// - The crossing detect input times all power-line activity.
// - Power-line receive data is read on line_rx, which only a receive-capable module drives.
// - Seven commands exist: lamps on, units off, raise, reduce, activate, deactivate, poll.
// - House codes are A to P and unit numbers 1 to 16 only.
// - A poll takes a count and a half-cycle timeout of 01-99; on timeout it answers !Z99 CR LF.
// - Received power-line data is reported as !, house letter, two-digit unit, CR LF.
`timescale 1ns/10ps
`default_nettype none
`include "spcb_consts.svh"
module spcb_bridge #(
  parameter int unsigned CLK_HZ = `SPCB_CLK_HZ,
  parameter int unsigned BURST_CYC = `SPCB_BURST_US * (`SPCB_CLK_HZ / `SPCB_US_PER_S)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_rx,
  output logic serial_tx,
  input wire logic serial_level_select,
  input wire logic frame_format_select,
  input wire logic rate_select_0,
  input wire logic rate_select_1,
  input wire logic rate_select_2,
  input wire logic crossing_detect,
  input wire logic line_rx,
  output logic line_tx
);
  spcb_pkg::spcb_core_t s, n;
  spcb_pkg::spcb_ucfg_t ucfg;
  logic rx_valid, tx_busy, zc_edge, is_poll, house_ok, unit_ok, rep_ok, poll_ok, tx_ok;
  logic [7:0] rx_byte, d_unit, d_rep;
  logic [6:0] code;
  logic [23:0] rx_next;

  // Two ASCII digits to a value, top bit flags both digits valid
  function automatic logic [7:0] dec2(input logic [7:0] hi, input logic [7:0] lo);
    logic [6:0] h;
    logic [6:0] l;
    h = 7'(hi - `SPCB_CH_0);
    l = 7'(lo - `SPCB_CH_0);
    dec2 = {(hi inside {[`SPCB_CH_0:`SPCB_CH_9]}) && (lo inside {[`SPCB_CH_0:`SPCB_CH_9]}),
            7'(h * 7'd10 + l)};
  endfunction : dec2

  // Command letters to function code, top bit flags a known command
  function automatic logic [6:0] cmd_code(input logic [23:0] c);
    case (c)
      `SPCB_STR_LAMP_ON: cmd_code = {1'b1, `SPCB_CODE_LAMP_ON};
      `SPCB_STR_UNIT_OFF: cmd_code = {1'b1, `SPCB_CODE_UNIT_OFF};
      `SPCB_STR_RAISE: cmd_code = {1'b1, `SPCB_CODE_RAISE};
      `SPCB_STR_REDUCE: cmd_code = {1'b1, `SPCB_CODE_REDUCE};
      `SPCB_STR_DEACT: cmd_code = {1'b1, `SPCB_CODE_DEACT};
      `SPCB_STR_ACT: cmd_code = {1'b1, `SPCB_CODE_ACT};
      default: cmd_code = 7'h00;
    endcase
  endfunction : cmd_code

  // Rate strap code to bit period in clocks
  function automatic logic [`SPCB_DIV_W-1:0] rate_div(input logic [2:0] code_in);
    case (code_in)
      3'h1: rate_div = `SPCB_DIV_W'(CLK_HZ / `SPCB_BAUD_4800);
      3'h2: rate_div = `SPCB_DIV_W'(CLK_HZ / `SPCB_BAUD_2400);
      3'h3: rate_div = `SPCB_DIV_W'(CLK_HZ / `SPCB_BAUD_1200);
      3'h4: rate_div = `SPCB_DIV_W'(CLK_HZ / `SPCB_BAUD_600);
      3'h5: rate_div = `SPCB_DIV_W'(CLK_HZ / `SPCB_BAUD_300);
      default: rate_div = `SPCB_DIV_W'(CLK_HZ / `SPCB_BAUD_9600);
    endcase
  endfunction : rate_div

  // Frame: start code, then each house and key bit followed by its complement
  function automatic logic [23:0] frame(input logic [3:0] h, input logic [5:0] k);
    frame = {`SPCB_START_CODE, 20'h0_0000};
    for (int i = 0; i < 4; i++) begin
      frame[19 - 2 * i -: 2] = {h[3 - i], ~h[3 - i]};
    end
    for (int i = 0; i < 6; i++) begin
      frame[11 - 2 * i -: 2] = {k[5 - i], ~k[5 - i]};
    end
  endfunction : frame

  // True when a shifted half-cycle history holds a whole frame
  function automatic logic frame_ok(input logic [23:0] f);
    frame_ok = f[23:20] == `SPCB_START_CODE;
    for (int i = 0; i < 10; i++) begin
      frame_ok = frame_ok && (f[2 * i + 1] != f[2 * i]);
    end
  endfunction : frame_ok

  function automatic logic [5:0] frame_key(input logic [23:0] f);
    for (int i = 0; i < 6; i++) begin
      frame_key[i] = f[2 * i + 1];
    end
  endfunction : frame_key

  function automatic logic [3:0] frame_house(input logic [23:0] f);
    for (int i = 0; i < 4; i++) begin
      frame_house[i] = f[2 * i + 13];
    end
  endfunction : frame_house

  // Host serial port
  assign ucfg = '{div: rate_div(s.strap.rate), inv: s.strap.inv, fmt7: s.strap.fmt7};
  spcb_uart u_uart (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(ucfg),
    .run(s.taken),
    .rx_pin(serial_rx),
    .tx_go(s.tx_go),
    .tx_byte(s.tx_byte),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte),
    .tx_busy(tx_busy),
    .tx_pin(serial_tx)
  );

  // Command string decode and half-cycle timing
  assign zc_edge = crossing_detect ^ s.zc_prev;
  assign rx_next = {s.sh[22:0], ~line_rx};
  assign code = cmd_code({s.buf_b[0], s.buf_b[1], s.buf_b[2]});
  assign is_poll = {s.buf_b[0], s.buf_b[1], s.buf_b[2], s.buf_b[3]} == `SPCB_STR_POLL;
  assign d_unit = dec2(s.buf_b[4], s.buf_b[5]);
  assign d_rep = dec2(s.buf_b[6], s.buf_b[7]);
  assign house_ok = s.buf_b[3] inside {[`SPCB_CH_A:`SPCB_CH_P]};
  assign unit_ok = d_unit[7] && (d_unit[6:0] inside {[7'd1:7'd16]});
  assign rep_ok = d_rep[7] && d_rep[6:0] != 7'h00;
  assign poll_ok = is_poll && d_unit[7] && d_unit[6:0] != 7'h00 && rep_ok;
  assign tx_ok = !is_poll && code[6] && house_ok && unit_ok && rep_ok;

  // Next state of the whole bridge
  always_comb begin
    n = s;
    n.tx_go = 1'b0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    n.zc_prev = crossing_detect;
    n.burst = s.burst != '0 ? s.burst - `SPCB_BURST_W'(1) : s.burst;
    if (!s.taken) begin
      n.taken = 1'b1;
      n.strap = '{serial_level_select, frame_format_select,
                  {rate_select_0, rate_select_1, rate_select_2}};
    end
    case (s.st)
      spcb_pkg::ST_COLLECT: begin
        if (s.idx == `SPCB_STR_END) begin
          n.idx = 4'h0;
          if (poll_ok) begin
            n.st = spcb_pkg::ST_POLL;
            n.rep = d_unit[6:0];
            n.tmo = d_rep[6:0];
            n.hc = 7'h00;
            n.sh = 24'h00_0000;
          end else if (tx_ok) begin
            n.st = spcb_pkg::ST_LINE_TX;
            n.house = 4'(s.buf_b[3] - `SPCB_CH_A);
            n.key_fn = code[5:0];
            n.sh = frame(4'(s.buf_b[3] - `SPCB_CH_A), d_unit[5:0]);
            n.bitc = `SPCB_FRAME_BITS;
            n.gap = 3'h0;
            n.rep = d_rep[6:0];
          end
        end else if (rx_valid && s.en) begin
          if (rx_byte == `SPCB_CH_START) begin
            n.idx = 4'h1;
          end else if (s.idx != 4'h0) begin
            n.buf_b[3'(s.idx - 4'h1)] = rx_byte;
            n.idx = s.idx + 4'h1;
          end
        end
      end
      spcb_pkg::ST_LINE_TX: begin
        if (zc_edge) begin
          if (s.gap != 3'h0) begin
            n.gap = s.gap - 3'h1;
          end else if (s.bitc != 5'h00) begin
            n.sh = {s.sh[22:0], 1'b0};
            n.bitc = s.bitc - 5'h01;
            if (s.sh[23]) begin
              n.burst = `SPCB_BURST_W'(BURST_CYC);
            end
            if (s.bitc == 5'h01) begin
              n.gap = `SPCB_GAP_HC;
            end
          end else if (s.rep == 7'h00) begin
            n.st = spcb_pkg::ST_COLLECT;
          end else begin
            n.sh = frame(s.house, s.key_fn);
            n.bitc = `SPCB_FRAME_BITS;
            n.rep = s.rep - 7'h01;
          end
        end
      end
      spcb_pkg::ST_POLL: begin
        if (zc_edge) begin
          n.sh = rx_next;
          n.hc = s.hc + 7'h01;
          n.ri = 3'h0;
          if (frame_ok(rx_next)) begin
            n.st = spcb_pkg::ST_REPLY;
            n.rh = `SPCB_CH_A + {4'h0, frame_house(rx_next)};
            n.rv = {1'b0, frame_key(rx_next)};
          end else if (s.hc + 7'h01 >= s.tmo) begin
            n.st = spcb_pkg::ST_REPLY;
            n.rh = `SPCB_CH_Z;
            n.rv = `SPCB_NODATA_VAL;
          end
        end
      end
      spcb_pkg::ST_REPLY: begin
        if (!s.tx_go && !tx_busy) begin
          if (s.ri == `SPCB_REPLY_END) begin
            n.rep = s.rep - 7'h01;
            n.st = s.rep == 7'h01 ? spcb_pkg::ST_COLLECT : spcb_pkg::ST_POLL;
            n.hc = 7'h00;
            n.sh = 24'h00_0000;
          end else begin
            n.tx_go = 1'b1;
            n.ri = s.ri + 3'h1;
            case (s.ri)
              3'h0: n.tx_byte = `SPCB_CH_BANG;
              3'h1: n.tx_byte = s.rh;
              3'h2: n.tx_byte = `SPCB_CH_0 + 8'(s.rv / 7'd10);
              3'h3: n.tx_byte = `SPCB_CH_0 + 8'(s.rv % 7'd10);
              3'h4: n.tx_byte = `SPCB_CH_CR;
              default: n.tx_byte = `SPCB_CH_LF;
            endcase
          end
        end
      end
      default: n.st = spcb_pkg::ST_COLLECT;
    endcase
    n.line_tx = n.burst != '0;
    // Register slave: answer prepared in setup, ready in access
    if (psel && !penable) begin
      n.pready = 1'b1;
      n.prdata = 32'h0000_0000;
      case (paddr)
        `SPCB_OFS_CTRL: n.prdata[0] = s.en;
        `SPCB_OFS_STATUS: n.prdata[6:0] = {s.st != spcb_pkg::ST_COLLECT, s.strap, s.taken};
        default: n.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && s.pready && pwrite && paddr == `SPCB_OFS_CTRL) begin
      n.en = pwdata[0];
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.en <= `SPCB_CTRL_EN_RST;
      s.zc_prev <= 1'b1; // Crossing pin idles high through its pull-up
    end else begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign line_tx = s.line_tx;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_strap;
    $rose(s.taken) |-> s.strap == $past({serial_level_select, frame_format_select,
                                          rate_select_0, rate_select_1, rate_select_2});
  endproperty
  a_strap: assert property (p_strap) else $error("straps not captured");

  property p_rate;
    s.strap.rate == 3'h5 |-> ucfg.div == `SPCB_DIV_W'(CLK_HZ / `SPCB_BAUD_300);
  endproperty
  a_rate: assert property (p_rate) else $error("slowest rate wrong");

  property p_rate_undef;
    s.strap.rate[2:1] == 2'b11 |-> ucfg.div == `SPCB_DIV_W'(CLK_HZ / `SPCB_BAUD_9600);
  endproperty
  a_rate_undef: assert property (p_rate_undef) else $error("undefined rate");

  property p_burst_zc;
    $rose(line_tx) |-> $past(zc_edge) && $past(s.st) == spcb_pkg::ST_LINE_TX;
  endproperty
  a_burst_zc: assert property (p_burst_zc) else $error("burst off crossing");

  property p_discard;
    s.st == spcb_pkg::ST_COLLECT && s.idx == 4'h0 && rx_valid && rx_byte != `SPCB_CH_START
      |=> s.idx == 4'h0 && s.st == spcb_pkg::ST_COLLECT ##1 !line_tx;
  endproperty
  a_discard: assert property (p_discard) else $error("stray byte kept");

  property p_unit;
    $rose(s.st == spcb_pkg::ST_LINE_TX) |-> frame_key(s.sh) inside {[6'd1:6'd16]};
  endproperty
  a_unit: assert property (p_unit) else $error("unit out of range");

  property p_timeout;
    $rose(s.st == spcb_pkg::ST_REPLY) && s.rh == `SPCB_CH_Z
      |-> $past(s.hc) + 7'h01 >= $past(s.tmo) && s.rv == `SPCB_NODATA_VAL;
  endproperty
  a_timeout: assert property (p_timeout) else $error("early no-data reply");

  property p_head;
    s.tx_go && s.ri == 3'h1 |-> s.tx_byte == `SPCB_CH_BANG ##[1:3] s.st == spcb_pkg::ST_REPLY;
  endproperty
  a_head: assert property (p_head) else $error("reply not led by mark");

  property p_poll_rx;
    s.st == spcb_pkg::ST_POLL && zc_edge && frame_ok(rx_next)
      |=> s.st == spcb_pkg::ST_REPLY && s.rh != `SPCB_CH_Z;
  endproperty
  a_poll_rx: assert property (p_poll_rx) else $error("received frame missed");
endmodule : spcb_bridge
`default_nettype wire

// File: src/spcb_consts.svh
// Constants of the serial power-line command bridge
`ifndef SPCB_CONSTS_SVH
`define SPCB_CONSTS_SVH
`define SPCB_CLK_HZ 20000000
`define SPCB_BAUD_9600 9600
`define SPCB_BAUD_4800 4800
`define SPCB_BAUD_2400 2400
`define SPCB_BAUD_1200 1200
`define SPCB_BAUD_600 600
`define SPCB_BAUD_300 300
`define SPCB_BURST_US 1000
`define SPCB_US_PER_S 1000000
`define SPCB_DIV_W 17
`define SPCB_BURST_W 20
`define SPCB_GAP_HC 3'h6
`define SPCB_FRAME_BITS 5'h18
`define SPCB_START_CODE 4'he
`define SPCB_OFS_CTRL 8'h00
`define SPCB_OFS_STATUS 8'h04
`define SPCB_CTRL_EN_RST 1'b1
`define SPCB_STR_END 4'h9
`define SPCB_REPLY_END 3'h6
`define SPCB_CH_START 8'h24
`define SPCB_CH_BANG 8'h21
`define SPCB_CH_A 8'h41
`define SPCB_CH_P 8'h50
`define SPCB_CH_Z 8'h5a
`define SPCB_CH_0 8'h30
`define SPCB_CH_9 8'h39
`define SPCB_CH_CR 8'h0d
`define SPCB_CH_LF 8'h0a
`define SPCB_NODATA_VAL 7'h63
`define SPCB_STR_LAMP_ON 24'h41_4c4f
`define SPCB_STR_UNIT_OFF 24'h41_554f
`define SPCB_STR_RAISE 24'h42_5254
`define SPCB_STR_REDUCE 24'h44_494d
`define SPCB_STR_DEACT 24'h4f_4646
`define SPCB_STR_ACT 24'h55_4f4e
`define SPCB_STR_POLL 32'h4449_4e41
`define SPCB_CODE_LAMP_ON 6'h16
`define SPCB_CODE_UNIT_OFF 6'h1e
`define SPCB_CODE_RAISE 6'h18
`define SPCB_CODE_REDUCE 6'h20
`define SPCB_CODE_DEACT 6'h1c
`define SPCB_CODE_ACT 6'h14
`endif

// File: src/spcb_pkg.sv
// Types of the serial power-line command bridge
`include "spcb_consts.svh"
package spcb_pkg;
  typedef enum logic [1:0] {ST_COLLECT, ST_LINE_TX, ST_POLL, ST_REPLY} spcb_state_t;
  typedef struct packed {logic inv; logic fmt7; logic [2:0] rate;} spcb_strap_t;
  typedef struct packed {logic [`SPCB_DIV_W-1:0] div; logic inv; logic fmt7;} spcb_ucfg_t;
  typedef struct packed {
    spcb_state_t st;
    logic taken;
    spcb_strap_t strap;
    logic en;
    logic [3:0] idx;
    logic [7:0][7:0] buf_b;
    logic [3:0] house;
    logic [5:0] key_fn;
    logic [6:0] rep;
    logic [6:0] tmo;
    logic [23:0] sh;
    logic [4:0] bitc;
    logic [2:0] gap;
    logic [`SPCB_BURST_W-1:0] burst;
    logic line_tx;
    logic zc_prev;
    logic [6:0] hc;
    logic [2:0] ri;
    logic [7:0] rh;
    logic [6:0] rv;
    logic tx_go;
    logic [7:0] tx_byte;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } spcb_core_t;
  typedef struct packed {
    logic rbusy;
    logic [`SPCB_DIV_W-1:0] rcnt;
    logic [3:0] rbit;
    logic [7:0] rsh;
    logic rv;
    logic [7:0] rd;
    logic tbusy;
    logic [`SPCB_DIV_W-1:0] tcnt;
    logic [3:0] tbit;
    logic [9:0] tsh;
    logic tpin;
  } spcb_uart_t;
endpackage : spcb_pkg

// File: src/spcb_uart.sv
// Host serial port with strap-selected format, polarity and rate
`timescale 1ns/10ps
`default_nettype none
module spcb_uart (
  input wire logic pclk,
  input wire logic presetn,
  input wire spcb_pkg::spcb_ucfg_t cfg,
  input wire logic run,
  input wire logic rx_pin,
  input wire logic tx_go,
  input wire logic [7:0] tx_byte,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic tx_busy,
  output logic tx_pin
);
  spcb_pkg::spcb_uart_t u, n;
  logic r;

  // Line level with polarity removed
  assign r = rx_pin ^ cfg.inv;

  // Receiver and transmitter next state
  always_comb begin
    n = u;
    n.rv = 1'b0;
    if (!u.rbusy) begin
      if (run && !r) begin
        n.rbusy = 1'b1;
        n.rcnt = cfg.div >> 1; // Sample mid-bit
        n.rbit = 4'h0;
      end
    end else if (u.rcnt != '0) begin
      n.rcnt = u.rcnt - 17'h1;
    end else begin
      n.rcnt = cfg.div - 17'h1;
      if (u.rbit == 4'h0) begin
        if (r) begin
          n.rbusy = 1'b0; // False start
        end else begin
          n.rbit = 4'h1;
        end
      end else if (u.rbit != 4'h9) begin
        n.rsh = {r, u.rsh[7:1]};
        n.rbit = u.rbit + 4'h1;
      end else begin
        n.rbusy = 1'b0;
        if (r && (!cfg.fmt7 || !(^u.rsh))) begin
          n.rv = 1'b1;
          n.rd = cfg.fmt7 ? {1'b0, u.rsh[6:0]} : u.rsh;
        end
      end
    end
    if (!u.tbusy) begin
      if (tx_go) begin
        n.tbusy = 1'b1;
        n.tsh = {1'b1, cfg.fmt7 ? {^tx_byte[6:0], tx_byte[6:0]} : tx_byte, 1'b0};
        n.tbit = 4'ha;
        n.tcnt = cfg.div - 17'h1;
      end
    end else if (u.tcnt != '0) begin
      n.tcnt = u.tcnt - 17'h1;
    end else if (u.tbit == 4'h1) begin
      n.tbusy = 1'b0;
    end else begin
      n.tsh = {1'b1, u.tsh[9:1]};
      n.tbit = u.tbit - 4'h1;
      n.tcnt = cfg.div - 17'h1;
    end
    n.tpin = n.tbusy ? (cfg.inv ^ n.tsh[0]) : ~cfg.inv;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      u <= '0;
      u.tpin <= 1'b1;
    end else begin
      u <= n;
    end
  end

  assign rx_valid = u.rv;
  assign rx_byte = u.rd;
  assign tx_busy = u.tbusy;
  assign tx_pin = u.tpin;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_idle_level;
    $past(run) && !u.tbusy |-> tx_pin == ~cfg.inv;
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle level wrong");

  property p_parity;
    u.rv && cfg.fmt7 |-> !(^$past(u.rsh)) && u.rd[7] == 1'b0;
  endproperty
  a_parity: assert property (p_parity) else $error("bad parity byte kept");
endmodule : spcb_uart
`default_nettype wire

// File: dv/spcb_host_model.sv
// Host serial port model: sends strings in the strapped format and collects the replies
`timescale 1ns/10ps
`default_nettype none
module spcb_host_model #(
  parameter int DIV = 50
) (
  input wire logic pclk,
  input wire logic armed,
  input wire logic inv,
  input wire logic fmt7,
  input wire logic from_dev,
  output logic to_dev
);
  logic [7:0] rxq[$];
  int frame_err = 0;
  logic line = 1'b1;
  // Logical level shown with the strapped polarity, idle at mark
  assign to_dev = line ^ inv;
  // One character: start, data LSB first, even parity or eighth bit, stop
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, fmt7 ? ^b[6:0] : b[7], b[6:0], 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      line <= f[i];
      repeat (DIV - 1) @(posedge pclk);
    end
  endtask : send_byte
  // Strings start with the start character and use capitals
  task automatic send_str(input string s);
    for (int i = 0; i < s.len(); i++) begin
      send_byte(s[i]);
    end
  endtask : send_str
  // Receiver samples mid-bit, checks parity and stop
  always begin : rx_proc
    logic [9:0] f;
    @(posedge pclk);
    if (armed && (from_dev ^ inv) == 1'b0) begin
      repeat (DIV / 2) @(posedge pclk);
      for (int i = 0; i < 10; i++) begin
        f[i] = from_dev ^ inv;
        if (i < 9) begin
          repeat (DIV) @(posedge pclk);
        end
      end
      if (f[0] || !f[9] || (fmt7 && (^f[8:1]))) begin
        frame_err++;
      end
      rxq.push_back(fmt7 ? {1'b0, f[7:1]} : f[8:1]);
    end
  end
endmodule : spcb_host_model
`default_nettype wire

// File: dv/test_serial_powerline_command_bridge.sv
// Self-checking bench for the serial power-line command bridge
`timescale 1ns/10ps
`default_nettype none
`include "spcb_consts.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_serial_powerline_command_bridge;
  localparam int unsigned CLK = 480000;
  localparam int unsigned BURST = 20;
  localparam int DIV = CLK / `SPCB_BAUD_9600;
  localparam logic [23:0] CSTR [6] = '{`SPCB_STR_LAMP_ON, `SPCB_STR_UNIT_OFF,
    `SPCB_STR_RAISE, `SPCB_STR_REDUCE, `SPCB_STR_DEACT, `SPCB_STR_ACT};
  localparam logic [5:0] CCODE [6] = '{`SPCB_CODE_LAMP_ON, `SPCB_CODE_UNIT_OFF,
    `SPCB_CODE_RAISE, `SPCB_CODE_REDUCE, `SPCB_CODE_DEACT, `SPCB_CODE_ACT};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, lfsr = 32'h4df7_c23d;
  logic pready, pslverr, serial_rx, serial_tx, line_tx, er;
  logic lvl = 1'b1, fmt = 1'b1, zc = 1'b1, lrx = 1'b1, armed = 1'b0;
  logic [2:0] rate = 3'b110;
  logic [3:0] h;
  logic [4:0] u;
  logic [23:0] fr;
  logic feed[$];
  logic seen[$];
  string bad[4];
  int fail_count = 0, checks = 0, burst_len = 0, bursts = 0, n0;

  always #25 pclk = ~pclk;

  spcb_bridge #(.CLK_HZ(CLK), .BURST_CYC(BURST)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_rx(serial_rx),
    .serial_tx(serial_tx), .serial_level_select(lvl), .frame_format_select(fmt),
    .rate_select_0(rate[2]), .rate_select_1(rate[1]), .rate_select_2(rate[0]),
    .crossing_detect(zc), .line_rx(lrx), .line_tx(line_tx));

  spcb_host_model #(.DIV(DIV)) host (.pclk(pclk), .armed(armed), .inv(lvl), .fmt7(fmt),
    .from_dev(serial_tx), .to_dev(serial_rx));

  // Mains half cycles of 40 clocks; carrier bits change mid half cycle
  always begin
    zc <= ~zc;
    repeat (3) @(posedge pclk);
    seen.push_back(line_tx);
    repeat (17) @(posedge pclk);
    lrx <= (feed.size() > 0) ? ~feed.pop_front() : 1'b1;
    repeat (20) @(posedge pclk);
  end

  // Every carrier burst lasts exactly the burst length
  always @(posedge pclk) begin
    if (line_tx === 1'b1) begin
      burst_len <= burst_len + 1;
    end else if (burst_len != 0) begin
      `CHK(burst_len, BURST)
      burst_len <= 0;
      bursts <= bursts + 1;
    end
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  // Expected line frame: start code, then true/complement pairs MSB first
  function automatic logic [23:0] frame(input logic [3:0] hc, input logic [5:0] k);
    logic [23:0] f;
    f = 24'h00_0000;
    f[23:20] = 4'b1110;
    for (int i = 0; i < 4; i++) begin
      f[19 - 2 * i] = hc[3 - i];
      f[18 - 2 * i] = ~hc[3 - i];
    end
    for (int i = 0; i < 6; i++) begin
      f[11 - 2 * i] = k[5 - i];
      f[10 - 2 * i] = ~k[5 - i];
    end
    return f;
  endfunction : frame

  // Skip idle and gap half cycles, then gather one frame
  task automatic take(output logic [23:0] f);
    f = 24'h00_0000;
    while (seen.size() > 0 && seen[0] !== 1'b1) begin
      void'(seen.pop_front());
    end
    for (int i = 23; i >= 0; i--) begin
      f[i] = (seen.size() > 0) ? seen.pop_front() : 1'b0;
    end
  endtask : take

  // APB transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    `CHK(n, 1)
  endtask : apb

  task automatic rst(input logic [4:0] s);
    @(posedge pclk);
    presetn <= 1'b0;
    {lvl, fmt, rate} <= s;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : rst

  task automatic reply(input string s);
    logic [7:0] b;
    while (host.rxq.size() < s.len()) begin
      @(posedge pclk);
    end
    for (int i = 0; i < s.len(); i++) begin
      b = host.rxq.pop_front();
      `CHK(b, s[i])
    end
  endtask : reply

  task automatic conclude();
    if (fail_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (100000) @(posedge pclk);
    fail_count++;
    conclude();
  end

  initial begin
    // Straps under random settings show in status and serial idle level
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      rst(lfsr[4:0]);
      apb(1'b0, `SPCB_OFS_STATUS, 32'h0000_0000);
      `CHK(rd[5:0], {lvl, fmt, rate, 1'b1})
      `CHK(serial_tx, ~lvl)
    end
    // Main setup: inverted, 7E1, undefined rate code acting as 9600
    rst(5'b11110);
    armed <= 1'b1;
    apb(1'b0, `SPCB_OFS_CTRL, 32'h0000_0000);
    `CHK(rd[0], `SPCB_CTRL_EN_RST)
    apb(1'b0, 8'h08, 32'h0000_0000);
    `CHK({er, rd}, {1'b1, 32'h0000_0000})
    // Each transmit command, first at the top house and unit
    for (int i = 0; i < 6; i++) begin
      lfsr = nxt(lfsr);
      h = (i == 0) ? 4'hf : lfsr[3:0];
      u = (i == 0) ? 5'd16 : {1'b0, lfsr[7:4]} + 5'd1;
      seen.delete();
      host.send_str($sformatf("$%s%c%02d01", CSTR[i], `SPCB_CH_A + h, u));
      repeat (66 * 40) @(posedge pclk);
      take(fr);
      `CHK(fr, frame(h, {1'b0, u}))
      take(fr);
      `CHK(fr, frame(h, CCODE[i]))
    end
    // Bad strings and a disabled bridge cause no line activity
    bad[0] = $sformatf("$%sQ0101", `SPCB_STR_ACT);
    bad[1] = $sformatf("$%sa0101", `SPCB_STR_ACT | 24'h20_2020);
    bad[2] = $sformatf("%sA0101", `SPCB_STR_ACT);
    bad[3] = $sformatf("$%sA0101", `SPCB_STR_ACT);
    for (int i = 0; i < 4; i++) begin
      if (i == 3) begin
        apb(1'b1, `SPCB_OFS_CTRL, 32'h0000_0000);
      end
      n0 = bursts;
      host.send_str(bad[i]);
      repeat (30 * 40) @(posedge pclk);
      `CHK(bursts, n0)
    end
    apb(1'b1, `SPCB_OFS_CTRL, 32'h0000_0001);
    // Poll with nothing on the line times out
    host.rxq.delete();
    host.send_str($sformatf("$%s0103", `SPCB_STR_POLL));
    reply("!Z99\r\n");
    // Poll that receives a frame for house C, unit 5
    host.rxq.delete();
    host.send_str($sformatf("$%s0199", `SPCB_STR_POLL));
    fr = frame(4'h2, 6'h05);
    for (int i = 23; i >= 0; i--) begin
      feed.push_back(fr[i]);
    end
    reply("!C05\r\n");
    // True polarity, 8N1 and rate code 000: a poll with the shortest timeout
    rst(5'b00000);
    host.rxq.delete();
    host.send_str($sformatf("$%s0101", `SPCB_STR_POLL));
    reply("!Z99\r\n");
    `CHK(host.frame_err, 0)
    conclude();
  end
endmodule : test_serial_powerline_command_bridge
`default_nettype wire
